// ==== logic/trig_ctl_pkg.sv ====
// =====================================================================
// shared constants for the measurement trigger control
// =====================================================================
package trig_ctl_pkg;

    // =================================================================
    // register port
    // =================================================================
    localparam int          ADDR_W         = 8;      // register address width
    localparam int          DATA_W         = 32;     // register data width
    localparam logic [7:0]  OFS_CTRL       = 8'h00;  // control bits and start
    localparam logic [7:0]  OFS_ATRIG_WAIT = 8'h04;  // auto trigger wait, us
    localparam logic [7:0]  OFS_CYCLES     = 8'h08;  // cycles per start
    localparam logic [7:0]  OFS_TRIG_DELAY = 8'h0C;  // trigger delay, signed us
    localparam logic [7:0]  OFS_DROPOUT    = 8'h10;  // dropout time, us
    localparam logic [7:0]  OFS_IQ_LEN     = 8'h14;  // i/q result length
    localparam logic [7:0]  OFS_STATUS     = 8'h18;  // state and busy
    localparam logic [7:0]  OFS_AUTO_CNT   = 8'h1C;  // auto triggered results
    localparam logic [7:0]  OFS_DONE_CNT   = 8'h20;  // cycles completed

    // =================================================================
    // control field positions
    // =================================================================
    localparam int CTRL_AUTO_BIT  = 0;  // auto trigger enable
    localparam int CTRL_TRACE_BIT = 1;  // trace mode
    localparam int CTRL_INT_BIT   = 2;  // internal level source
    localparam int CTRL_SLOPE_BIT = 3;  // negative slope
    localparam int CTRL_ROLE_LSB  = 4;  // sync role, two bits
    localparam int CTRL_START_BIT = 8;  // write one to start

    // =================================================================
    // times, programmed in microseconds
    // =================================================================
    localparam real ATRIG_MIN_S   = 0.1;
    localparam real ATRIG_MAX_S   = 5.0;
    localparam real ATRIG_RST_S   = 0.3;
    localparam real DELAY_MIN_S   = -5.0;
    localparam real DELAY_MAX_S   = 10.0;
    localparam real DELAY_RST_S   = 0.0;
    localparam real DROP_MIN_S    = 0.00;
    localparam real DROP_MAX_S    = 10.00;
    localparam real DROP_RST_S    = 0.00;
    localparam real US_PER_S      = 1.0e6;
    localparam int  ATRIG_MIN_US  = int'(ATRIG_MIN_S * US_PER_S);
    localparam int  ATRIG_MAX_US  = int'(ATRIG_MAX_S * US_PER_S);
    localparam int  ATRIG_RST_US  = int'(ATRIG_RST_S * US_PER_S);
    localparam int  DELAY_MIN_US  = int'(DELAY_MIN_S * US_PER_S);
    localparam int  DELAY_MAX_US  = int'(DELAY_MAX_S * US_PER_S);
    localparam int  DELAY_RST_US  = int'(DELAY_RST_S * US_PER_S);
    localparam int  DROP_MIN_US   = int'(DROP_MIN_S * US_PER_S);
    localparam int  DROP_MAX_US   = int'(DROP_MAX_S * US_PER_S);
    localparam int  DROP_RST_US   = int'(DROP_RST_S * US_PER_S);

    // =================================================================
    // clock and time base
    // =================================================================
    localparam int  CLK_PERIOD_PS = 8000;       // 125 MHz ref_clk
    localparam int  UNIT_PS       = 1000000;    // one microsecond
    localparam int  TICK_CYCLES   = UNIT_PS / CLK_PERIOD_PS;

    // =================================================================
    // counts
    // =================================================================
    localparam int  CYCLES_MIN    = 1;
    localparam int  CYCLES_MAX    = 131072;
    localparam int  CYCLES_RST    = 1;
    localparam int  IQ_LEN_MIN    = 1;
    localparam int  IQ_LEN_MAX    = 15000000;
    localparam int  IQ_LEN_RST    = 1024;

    // =================================================================
    // enumerations
    // =================================================================
    typedef enum logic [1:0] {
        ROLE_OFF  = 2'b00,
        ROLE_SEND = 2'b01,
        ROLE_RECV = 2'b10
    } sync_role_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT    = 2'b01,
        ST_DELAY   = 2'b10,
        ST_MEASURE = 2'b11
    } meas_state_e;

endpackage

// ==== logic/tick_down_timer.sv ====
`timescale 1ns/100ps
// =====================================================================
// down-counter in microsecond ticks
// =====================================================================
module tick_down_timer #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         tick,       // one-cycle time base enable
    input  wire logic         load,       // load wins over counting
    input  wire logic [W-1:0] load_val,   // start value in ticks
    output logic              expired     // count has reached zero
);
    logic [W-1:0] cnt_r;  // remaining ticks

    // =================================================================
    // counter
    // =================================================================
    // decrement only on the tick, so counts are true time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (tick && cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign expired = (cnt_r == '0);

    AST_TICK_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(load) && !$past(tick) && !$past(rst) |-> $stable(cnt_r))
        else $error("timer moved without a tick");

endmodule // tick_down_timer

// ==== logic/meas_trigger_ctl.sv ====
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module meas_trigger_ctl
    import trig_ctl_pkg::*;
#(
    parameter int CYC_MAX = CYCLES_MAX,   // largest cycle count
    parameter int IQ_MAX  = IQ_LEN_MAX    // largest i/q length
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic [trig_ctl_pkg::ADDR_W-1:0] addr,
    input  wire logic [trig_ctl_pkg::DATA_W-1:0] wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic [trig_ctl_pkg::DATA_W-1:0] rdata,
    input  wire logic                      trig_in,
    input  wire logic                      level_above,
    input  wire logic                      result_ready,
    input  wire logic                      sync_trig_in,
    output logic                           sync_trig_out,
    output logic                           integ_start,
    output logic [31:0]                    pre_offset_us,
    output logic                           busy,
    output logic                           avg_single,
    output logic [23:0]                    iq_result_length,
    output logic [1:0]                     sync_role
);
    import trig_ctl_pkg::*;

    // =================================================================
    // elaboration checks
    // =================================================================
    if (CYC_MAX < 1 || CYC_MAX > CYCLES_MAX) begin : g_bad_cyc
        $error("CYC_MAX out of range");
    end
    if (IQ_MAX < 1 || IQ_MAX > IQ_LEN_MAX) begin : g_bad_iq
        $error("IQ_MAX out of range");
    end

    // clamp a signed value into a window; out of range writes saturate
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // =================================================================
    // state and registers
    // =================================================================
    meas_state_e         state_r;         // measurement sequencer
    meas_state_e         state_nxt;
    logic                auto_en_r;       // auto trigger enable
    logic                trace_r;         // trace mode
    logic                int_src_r;       // internal level source
    logic                slope_neg_r;     // negative slope
    sync_role_e          role_r;          // sync role
    logic [31:0]         atrig_r;         // auto wait, us
    logic [31:0]         cycles_r;        // cycles per start
    logic signed [31:0]  delay_r;         // trigger delay, us
    logic [31:0]         drop_r;          // dropout, us
    logic [23:0]         iq_len_r;        // i/q length
    logic [17:0]         done_r;          // cycles completed
    logic [17:0]         done_nxt;
    logic [17:0]         auto_cnt_r;      // auto-triggered results
    logic [17:0]         auto_cnt_nxt;
    logic [31:0]         rdata_r;         // read data, one cycle late
    logic                integ_r;         // start of integration pulse
    logic                sync_out_r;      // sender trigger pulse
    logic [31:0]         pre_r;           // pre-trigger span
    logic [6:0]          div_r;           // microsecond divider
    logic                on_side_prev_r;  // last level side
    logic                armed_r;         // dropout satisfied

    // =================================================================
    // decode
    // =================================================================
    wire        wr_ctrl   = wr && addr == OFS_CTRL;
    wire        start_req = wr_ctrl && wdata[CTRL_START_BIT];
    wire        auto_on   = wr_ctrl && wdata[CTRL_AUTO_BIT] && !auto_en_r;
    wire        auto_act  = auto_en_r && trace_r;
    wire [1:0]  role_w    = wdata[CTRL_ROLE_LSB +: 2];
    wire [6:0]  tick_last = 7'(TICK_CYCLES - 1);
    wire        tick      = (div_r == tick_last);

    // =================================================================
    // microsecond time base
    // =================================================================
    // one enable pulse every TICK_CYCLES clocks
    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    // =================================================================
    // register writes
    // =================================================================
    // every time value saturates into its legal window
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auto_en_r   <= 1'b0;
            trace_r     <= 1'b0;
            int_src_r   <= 1'b0;
            slope_neg_r <= 1'b0;
            role_r      <= ROLE_OFF;
            atrig_r     <= 32'(ATRIG_RST_US);
            cycles_r    <= 32'(CYCLES_RST);
            delay_r     <= 32'(DELAY_RST_US);
            drop_r      <= 32'(DROP_RST_US);
            iq_len_r    <= 24'(IQ_LEN_RST);
        end else if (wr) begin
            unique case (addr)
                OFS_CTRL: begin
                    auto_en_r   <= wdata[CTRL_AUTO_BIT];
                    trace_r     <= wdata[CTRL_TRACE_BIT];
                    int_src_r   <= wdata[CTRL_INT_BIT];
                    slope_neg_r <= wdata[CTRL_SLOPE_BIT];
                    // illegal role code falls back to off
                    role_r <= (role_w == ROLE_SEND) ? ROLE_SEND :
                              (role_w == ROLE_RECV) ? ROLE_RECV : ROLE_OFF;
                end
                OFS_ATRIG_WAIT: atrig_r  <= clamp(wdata, ATRIG_MIN_US, ATRIG_MAX_US);
                OFS_CYCLES:     cycles_r <= clamp(wdata, CYCLES_MIN, CYC_MAX);
                OFS_TRIG_DELAY: delay_r  <= clamp(wdata, DELAY_MIN_US, DELAY_MAX_US);
                OFS_DROPOUT:    drop_r   <= clamp(wdata, DROP_MIN_US, DROP_MAX_US);
                OFS_IQ_LEN:     iq_len_r <= 24'(clamp(wdata, IQ_LEN_MIN, IQ_MAX));
                default: begin
                    // unmapped and read-only offsets ignore writes
                end
            endcase
        end
    end

    // =================================================================
    // internal level trigger with dropout
    // =================================================================
    wire on_side  = slope_neg_r ? !level_above : level_above; // trigger side
    wire lvl_edge = on_side && !on_side_prev_r;
    wire drop_done;
    wire lvl_fire = lvl_edge && armed_r;

    // dropout timer reloads while on the trigger side, runs while off it
    tick_down_timer #(.W(32)) u_drop (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .load     (on_side),
        .load_val (drop_r),
        .expired  (drop_done)
    );

    // arm only after the signal stayed away for the dropout time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            on_side_prev_r <= 1'b1;
            armed_r        <= 1'b0;
        end else begin
            on_side_prev_r <= on_side;
            if (lvl_edge) begin
                armed_r <= 1'b0;
            end else if (!on_side && drop_done) begin
                armed_r <= 1'b1;
            end
        end
    end

    // =================================================================
    // trigger selection
    // =================================================================
    // a receiver takes its real trigger only from the sender's trigger, never from trig_in or the level
    wire real_fire  = (role_r == ROLE_RECV) ? sync_trig_in :
                      (int_src_r ? lvl_fire : trig_in);
    wire wait_done;
    wire delay_done;
    wire in_wait    = (state_r == ST_WAIT);
    wire auto_fire  = in_wait && auto_act && wait_done && !real_fire;
    wire fire       = in_wait && (real_fire || auto_fire);
    wire pos_delay  = (delay_r > 0);
    wire enter_wait = (state_nxt == ST_WAIT) && (state_r != ST_WAIT);
    wire [31:0] neg_span = 32'(-delay_r);

    // wait time restarts whenever the sequencer arms
    tick_down_timer #(.W(32)) u_wait (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .load     (enter_wait),
        .load_val (atrig_r),
        .expired  (wait_done)
    );

    // positive trigger delay only; negative spans use history
    tick_down_timer #(.W(32)) u_delay (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (tick),
        .load     (fire && pos_delay),
        .load_val (delay_r),
        .expired  (delay_done)
    );

    // =================================================================
    // sequencer
    // =================================================================
    wire [17:0] done_inc = done_r + 18'h00001;
    wire        last_res = ({14'h0000, done_inc} >= cycles_r);
    wire        go_meas  = (fire && !pos_delay) || (state_r == ST_DELAY && delay_done);

    always_comb begin
        state_nxt = state_r;
        done_nxt  = done_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start_req) begin
                    state_nxt = ST_WAIT;
                    done_nxt  = '0;
                end
            end
            ST_WAIT: begin
                if (fire) begin
                    state_nxt = pos_delay ? ST_DELAY : ST_MEASURE;
                end
            end
            ST_DELAY: begin
                if (delay_done) begin
                    state_nxt = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (result_ready) begin
                    done_nxt  = done_inc;
                    // re-arm without host help until the count is met
                    state_nxt = last_res ? ST_IDLE : ST_WAIT;
                end
            end
        endcase
    end

    // auto-triggered results; one scalar start can only reach one
    always_comb begin
        auto_cnt_nxt = auto_cnt_r;
        if (auto_fire && !(cycles_r == 32'h0000_0001 && auto_cnt_r != '0)) begin
            auto_cnt_nxt = auto_cnt_r + 18'h00001;
        end
        if (auto_on) begin
            // a fresh enable restarts the count, a same-cycle event still counts
            auto_cnt_nxt = auto_fire ? 18'h00001 : 18'h00000;
        end
    end

    // sequencer state, counters and output pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            done_r     <= '0;
            auto_cnt_r <= '0;
            integ_r    <= 1'b0;
            sync_out_r <= 1'b0;
            pre_r      <= '0;
        end else begin
            state_r    <= state_nxt;
            done_r     <= done_nxt;
            auto_cnt_r <= auto_cnt_nxt;
            integ_r    <= go_meas;
            sync_out_r <= fire && (role_r == ROLE_SEND);
            if (fire) begin
                pre_r <= pos_delay ? 32'h0000_0000 : neg_span;
            end
        end
    end

    // =================================================================
    // register reads
    // =================================================================
    logic [31:0] rd_mux;  // selected read word
    assign rd_mux =
        (addr == OFS_CTRL)       ? {26'h0, role_r, slope_neg_r, int_src_r, trace_r, auto_en_r} :
        (addr == OFS_ATRIG_WAIT) ? atrig_r :
        (addr == OFS_CYCLES)     ? cycles_r :
        (addr == OFS_TRIG_DELAY) ? delay_r :
        (addr == OFS_DROPOUT)    ? drop_r :
        (addr == OFS_IQ_LEN)     ? {8'h00, iq_len_r} :
        (addr == OFS_STATUS)     ? {28'h0, armed_r, busy, state_r} :
        (addr == OFS_AUTO_CNT)   ? {14'h0000, auto_cnt_r} :
        (addr == OFS_DONE_CNT)   ? {14'h0000, done_r} : 32'h0000_0000;

    // data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // =================================================================
    // outputs
    // =================================================================
    assign rdata            = rdata_r;
    assign integ_start      = integ_r;
    assign sync_trig_out    = sync_out_r;
    assign pre_offset_us    = pre_r;
    assign busy             = (state_r != ST_IDLE);
    assign avg_single       = auto_act;
    assign iq_result_length = iq_len_r;
    assign sync_role        = role_r;

    // =================================================================
    // checks
    // =================================================================
    AST_AUTO_FIRE: assert property (@(posedge ref_clk) disable iff (rst)
        in_wait && auto_act && wait_done && !real_fire |=> integ_start || state_r == ST_DELAY)
        else $error("auto trigger did not fire");
    AST_WAIT_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
        atrig_r >= ATRIG_MIN_US && atrig_r <= ATRIG_MAX_US)
        else $error("auto wait out of range");
    AST_ONE_TRACE: assert property (@(posedge ref_clk) disable iff (rst)
        auto_fire |-> avg_single && trace_r)
        else $error("auto trigger outside trace mode");
    AST_SCALAR_CNT: assert property (@(posedge ref_clk) disable iff (rst)
        cycles_r == 32'h0000_0001 && auto_cnt_r != 18'h00000 && !auto_on
        |=> auto_cnt_r == $past(auto_cnt_r))
        else $error("scalar auto count moved past one");
    AST_CYC_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
        cycles_r >= 1 && cycles_r <= 32'(CYCLES_MAX))
        else $error("cycle count out of range");
    AST_REARM: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == ST_MEASURE && result_ready && !last_res |=> state_r == ST_WAIT && busy)
        else $error("no internal re-arm");
    AST_NEG_DELAY: assert property (@(posedge ref_clk) disable iff (rst)
        fire && !pos_delay |=> integ_start && pre_offset_us == $past(neg_span))
        else $error("non-positive delay did not start at once");
    AST_DROPOUT: assert property (@(posedge ref_clk) disable iff (rst)
        lvl_fire |=> !armed_r)
        else $error("level trigger did not disarm");
    AST_IQ_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
        iq_len_r >= 24'(IQ_LEN_MIN) && iq_len_r <= 24'(IQ_LEN_MAX))
        else $error("i/q length out of range");
    AST_SENDER: assert property (@(posedge ref_clk) disable iff (rst)
        fire && role_r == ROLE_SEND |=> sync_trig_out ##1 !sync_trig_out || fire)
        else $error("sender trigger missing");

endmodule // meas_trigger_ctl

// ==== dv/host_cmd_model.sv ====
`timescale 1ns/100ps
// ====================================================
// host side: issues register writes and reads
// ====================================================
module host_cmd_model (
    input  wire logic        ref_clk,
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata
);
    // bus idle at time zero
    initial begin
        {addr, wdata, wr, rd} = '0;
    end
    // one-cycle write; values go out unchanged, out of range ones included
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    // data stand only the cycle after the strobe, so sample mid-cycle
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
endmodule // host_cmd_model

// ==== dv/meas_trigger_ctl_test.sv ====
`timescale 1ns/100ps
// ====================================================
// self-checking bench
// ====================================================
module meas_trigger_ctl_test;
    import trig_ctl_pkg::*;
    logic        ref_clk = 1'b0;  // 125 MHz
    logic        rst     = 1'b1;  // held 8 cycles
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, pre_offset_us;
    logic        wr, rd, sync_trig_out, integ_start, busy, avg_single;
    logic        trig_in = 1'b0, result_ready = 1'b0;
    logic        level_above = 1'b0, sync_trig_in = 1'b0;  // level source and sender trigger
    logic [23:0] iq_result_length;
    logic [1:0]  sync_role;
    logic [15:0] seed = 16'h0003;  // random source start
    int          bad_count = 0, comparisons = 0;
    always #4 ref_clk = ~ref_clk;
    meas_trigger_ctl i_meas_trigger_ctl (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .trig_in(trig_in), .level_above(level_above), .result_ready(result_ready),
        .sync_trig_in(sync_trig_in), .sync_trig_out(sync_trig_out), .integ_start(integ_start),
        .pre_offset_us(pre_offset_us), .busy(busy), .avg_single(avg_single),
        .iq_result_length(iq_result_length), .sync_role(sync_role));
    host_cmd_model i_host_cmd_model (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    // ====================================================
    // helpers
    // ====================================================
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic reg_is(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_host_cmd_model.get(a, d);
        check(what, d, exp);
    endtask
    // trigger, time the integration start, then hand back a result
    // src 0 external pin, 1 internal level, 2 sender trigger
    task automatic one_cycle(input int lo, input int hi, input logic snd, input logic [1:0] src);
        int n;
        n = 0;
        @(posedge ref_clk) {sync_trig_in, level_above, trig_in} <= 3'b001 << src;
        @(posedge ref_clk) {sync_trig_in, level_above, trig_in} <= 3'b000;
        @(negedge ref_clk);
        while (integ_start !== 1'b1 && n < 2000) begin
            @(negedge ref_clk) n++;
        end
        check("start span", 32'(n >= lo && n <= hi), 1);
        check("sender out", sync_trig_out, snd);
        @(posedge ref_clk) result_ready <= 1'b1;
        @(posedge ref_clk) result_ready <= 1'b0;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test;
    end
    // ====================================================
    // tests
    // ====================================================
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        reg_is("auto wait", OFS_ATRIG_WAIT, ATRIG_RST_US);
        reg_is("cycles", OFS_CYCLES, CYCLES_RST);
        reg_is("delay", OFS_TRIG_DELAY, DELAY_RST_US);
        reg_is("dropout", OFS_DROPOUT, DROP_RST_US);
        reg_is("iq length", OFS_IQ_LEN, IQ_LEN_RST);
        reg_is("unmapped", 8'hFC, 32'h0);
        $display("defaults done");
        // random lengths reach the design; zero is raised to one
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            i_host_cmd_model.put(OFS_IQ_LEN, {16'h0, seed});
            reg_is("iq length", OFS_IQ_LEN, (seed == 0) ? 1 : seed);
            check("iq port", iq_result_length, (seed == 0) ? 1 : seed);
        end
        i_host_cmd_model.put(OFS_ATRIG_WAIT, 32'h0);
        reg_is("wait floor", OFS_ATRIG_WAIT, ATRIG_MIN_US);
        i_host_cmd_model.put(OFS_CYCLES, 32'h0);
        reg_is("cycles floor", OFS_CYCLES, CYCLES_MIN);
        // every role and every auto/trace pairing
        for (int r = 0; r < 4; r++) begin
            i_host_cmd_model.put(OFS_CTRL, 32'(r << 4 | r));
            repeat (2) @(negedge ref_clk);
            check("role", sync_role, (r == 3) ? 0 : r);
            check("one trace", avg_single, r == 3);
        end
        reg_is("auto count", OFS_AUTO_CNT, 32'h0);
        $display("settings done");
        // sender, three cycles from one start, back to back
        i_host_cmd_model.put(OFS_CTRL, 32'h10);
        i_host_cmd_model.put(OFS_CYCLES, 32'h3);
        i_host_cmd_model.put(OFS_CTRL, 32'h110);
        @(negedge ref_clk) check("busy", busy, 1);
        for (int c = 0; c < 3; c++) one_cycle(0, 0, 1, 2'd0);
        repeat (2) @(negedge ref_clk);
        check("idle", busy, 0);
        reg_is("done", OFS_DONE_CNT, 32'h3);
        $display("repeat done");
        // positive delay of 2 us, then a negative one
        i_host_cmd_model.put(OFS_CYCLES, 32'h1);
        i_host_cmd_model.put(OFS_TRIG_DELAY, 32'h2);
        i_host_cmd_model.put(OFS_CTRL, 32'h100);
        one_cycle(2 * TICK_CYCLES - TICK_CYCLES, 2 * TICK_CYCLES + TICK_CYCLES, 0, 2'd0);
        // negative delay on a receiver started by the sender's trigger
        i_host_cmd_model.put(OFS_TRIG_DELAY, 32'hFFFFFFFD);
        i_host_cmd_model.put(OFS_CTRL, 32'h120);
        one_cycle(0, 0, 0, 2'd2);
        check("pre offset", pre_offset_us, 32'h3);
        $display("delay done");
        // level trigger: a second crossing inside the dropout time is refused
        i_host_cmd_model.put(OFS_DROPOUT, 32'h3);
        i_host_cmd_model.put(OFS_CYCLES, 32'h2);
        i_host_cmd_model.put(OFS_CTRL, 32'h104);
        one_cycle(0, 0, 0, 2'd1);
        @(posedge ref_clk) level_above <= 1'b1;
        @(posedge ref_clk) level_above <= 1'b0;
        @(negedge ref_clk) check("dropout refused", integ_start, 0);
        repeat (4 * TICK_CYCLES) @(posedge ref_clk);
        one_cycle(0, 0, 0, 2'd1);
        repeat (2) @(negedge ref_clk);
        check("idle", busy, 0);
        $display("dropout done");
        stop_test;
    end
endmodule // meas_trigger_ctl_test
